// [common/uhpd_defs.svh]
// Register indices, field positions, reset values, status bits and boost step of the hub port config block
`ifndef UHPD_DEFS_SVH
`define UHPD_DEFS_SVH

// Register indices; byte address is four times the index
`define UHPD_IDX_BOOST_UPPER 8'hf7
`define UHPD_IDX_BOOST_LOWER 8'hf8
`define UHPD_IDX_PIN_SWAP 8'hfa
`define UHPD_IDX_STATUS 8'hfd

// Reset values
`define UHPD_RST_BOOST_UPPER 8'h00
`define UHPD_RST_BOOST_LOWER 8'h00
`define UHPD_RST_PIN_SWAP 8'h00

// Boost field least significant bits
`define UHPD_P5_LSB 0
`define UHPD_P6_LSB 2
`define UHPD_P7_LSB 4
`define UHPD_P1_LSB 0
`define UHPD_P2_LSB 2
`define UHPD_P3_LSB 4
`define UHPD_P4_LSB 6
`define UHPD_UPPER_MASK 8'h3f

// Swap field: bit 0 upstream, bit n downstream port n
`define UHPD_SWAP_UPSTREAM 0

// Status register bits
`define UHPD_STS_FROZEN 0
`define UHPD_STS_PENDING 1

// Boost step in percent per code step
`define UHPD_BOOST_STEP_PCT 4

`endif

// [common/uhpd_pkg.sv]
// Types shared by the hub port drive and swap configuration block
package uhpd_pkg;

  typedef enum logic [1:0] {
    drv_normal,
    drv_low,
    drv_medium,
    drv_high
  } uhpd_drive_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } uhpd_line_t;

endpackage

// [logic/uhpd_boost_decode.sv]
// Decodes two-bit boost codes into drive strength levels for each port
`timescale 1ns/100ps
`default_nettype none
`include "uhpd_defs.svh"

module uhpd_boost_decode #(
  parameter int N = 7
) (
  input wire logic [N-1:0][1:0] code,
  output uhpd_pkg::uhpd_drive_t level [N],
  output logic [N-1:0][3:0] boost_pct
);
  import uhpd_pkg::*;

  initial begin
    if (N < 1) begin
      $error("uhpd_boost_decode: N must be at least 1");
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_port
    assign level[i] = code[i] == 2'h0 ? drv_normal :   // RULE3
                      code[i] == 2'h1 ? drv_low :      // RULE4
                      code[i] == 2'h2 ? drv_medium : drv_high;
    // Nominal elevation, zero for normal drive
    assign boost_pct[i] = 4'(code[i] * `UHPD_BOOST_STEP_PCT);   // RULE4
  end

endmodule
`default_nettype wire

// [logic/uhpd_pin_swap.sv]
// Exchanges positive and negative data line pads per port
`timescale 1ns/100ps
`default_nettype none

module uhpd_pin_swap #(
  parameter int N = 8
) (
  input wire logic [N-1:0] swap,
  input wire uhpd_pkg::uhpd_line_t [N-1:0] core_tx,
  input wire uhpd_pkg::uhpd_line_t [N-1:0] core_oe_n,
  output uhpd_pkg::uhpd_line_t [N-1:0] core_rx,
  output uhpd_pkg::uhpd_line_t [N-1:0] pin_out,
  output uhpd_pkg::uhpd_line_t [N-1:0] pin_oe_n,
  input wire uhpd_pkg::uhpd_line_t [N-1:0] pin_in
);
  import uhpd_pkg::*;

  initial begin
    if (N < 1) begin
      $error("uhpd_pin_swap: N must be at least 1");
    end
  end

  // Pure steering: no register so the line timing stays untouched
  for (genvar i = 0; i < N; i++) begin : g_port
    assign pin_out[i] = swap[i] ? {core_tx[i].neg, core_tx[i].pos} : core_tx[i];   // RULE7 RULE8
    assign pin_oe_n[i] = swap[i] ? {core_oe_n[i].neg, core_oe_n[i].pos} : core_oe_n[i];
    assign core_rx[i] = swap[i] ? {pin_in[i].neg, pin_in[i].pos} : pin_in[i];   // RULE8
  end

endmodule
`default_nettype wire

// [logic/uhpd_cfg_top.sv]
// Hub port drive boost and data pin swap configuration registers over APB
//
// Overview of operation
// (RULE1) Upper boost register: port 7 bits 5:4, port 6 3:2, port 5 1:0, 7:6 reserved.
// (RULE2) Lower boost register: port 4 bits 7:6, port 3 5:4, port 2 3:2, port 1 1:0.
// (RULE3) Boost code zero drives the port at normal strength.
// (RULE4) Codes 01, 10, 11 give low, medium, high boost, about 4, 8, 12 percent.
// (RULE5) Software should keep boost at zero unless signal levels need correcting.
// (RULE6) Swap field holds eight bits, one per upstream or downstream port.
// (RULE7) Swap bit 0 keeps positive line on positive pin, negative on negative.
// (RULE8) Swap bit 1 exchanges the positive and negative pins of that port.
// (RULE9) Swap bit 7 exchanges the data pins of downstream port 7.
// (RULE10) Swap bits 6 to 1 serve the same numbered port; bit 0 the upstream port.
// (RULE11) Settings are applied before attach and held constant while attached.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "uhpd_defs.svh"

module uhpd_cfg_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_DS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hub_attached,
  output uhpd_pkg::uhpd_drive_t port1_drive_level,
  output uhpd_pkg::uhpd_drive_t port2_drive_level,
  output uhpd_pkg::uhpd_drive_t port3_drive_level,
  output uhpd_pkg::uhpd_drive_t port4_drive_level,
  output uhpd_pkg::uhpd_drive_t port5_drive_level,
  output uhpd_pkg::uhpd_drive_t port6_drive_level,
  output uhpd_pkg::uhpd_drive_t port7_drive_level,
  output logic [NUM_DS-1:0][3:0] boost_pct,
  input wire uhpd_pkg::uhpd_line_t [NUM_DS:0] core_tx,
  input wire uhpd_pkg::uhpd_line_t [NUM_DS:0] core_oe_n,
  output uhpd_pkg::uhpd_line_t [NUM_DS:0] core_rx,
  output uhpd_pkg::uhpd_line_t [NUM_DS:0] data_pin_out,
  output uhpd_pkg::uhpd_line_t [NUM_DS:0] data_pin_oe_n,
  input wire uhpd_pkg::uhpd_line_t [NUM_DS:0] data_pin_in
);
  import uhpd_pkg::*;

  initial begin
    if (ADDR_W < 10 || ADDR_W > 32) begin
      $error("uhpd_cfg_top: ADDR_W must be 10 to 32");
    end
    if (NUM_DS != 7) begin
      $error("uhpd_cfg_top: register layout serves exactly seven ports");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [ADDR_W-1:0] ADDR_UPPER = ADDR_W'({`UHPD_IDX_BOOST_UPPER, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_LOWER = ADDR_W'({`UHPD_IDX_BOOST_LOWER, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_SWAP = ADDR_W'({`UHPD_IDX_PIN_SWAP, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'({`UHPD_IDX_STATUS, 2'h0});

  function automatic logic [1:0] boost_field(input logic [7:0] r, input int lsb);
    boost_field = r[lsb +: 2];
  endfunction

  wire logic access = psel && penable;
  wire logic hit_upper = paddr == ADDR_UPPER;
  wire logic hit_lower = paddr == ADDR_LOWER;
  wire logic hit_swap = paddr == ADDR_SWAP;
  wire logic hit_status = paddr == ADDR_STATUS;
  wire logic mapped = hit_upper || hit_lower || hit_swap || hit_status;
  // Status is read-only; a write there is refused like an unmapped address
  wire logic bad_access = !mapped || (pwrite && hit_status);
  wire logic wr_lane0 = access && pwrite && pstrb[0] && !bad_access;
  wire logic wr_upper = wr_lane0 && hit_upper;
  wire logic wr_lower = wr_lane0 && hit_lower;
  wire logic wr_swap = wr_lane0 && hit_swap;

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers

  logic [7:0] downstream_upper_drive_boost;
  logic [7:0] downstream_lower_drive_boost;
  logic [7:0] data_pin_polarity_swap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      downstream_upper_drive_boost <= `UHPD_RST_BOOST_UPPER;
      downstream_lower_drive_boost <= `UHPD_RST_BOOST_LOWER;
      data_pin_polarity_swap <= `UHPD_RST_PIN_SWAP;
    end else begin
      if (wr_upper) begin
        // Reserved bits 7:6 are not stored
        downstream_upper_drive_boost <= pwdata[7:0] & `UHPD_UPPER_MASK;   // RULE1
      end
      if (wr_lower) begin
        downstream_lower_drive_boost <= pwdata[7:0];   // RULE2
      end
      if (wr_swap) begin
        data_pin_polarity_swap <= pwdata[7:0];   // RULE6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied copies: follow software until attach, then frozen

  logic [7:0] applied_upper;
  logic [7:0] applied_lower;
  logic [7:0] data_pin_swap_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_upper <= `UHPD_RST_BOOST_UPPER;
      applied_lower <= `UHPD_RST_BOOST_LOWER;
      data_pin_swap_mask <= `UHPD_RST_PIN_SWAP;
    end else if (!hub_attached) begin
      // A write while attached waits here until the next detach
      applied_upper <= downstream_upper_drive_boost;   // RULE11
      applied_lower <= downstream_lower_drive_boost;
      data_pin_swap_mask <= data_pin_polarity_swap;
    end
  end

  wire logic pending = (applied_upper != downstream_upper_drive_boost) ||
                       (applied_lower != downstream_lower_drive_boost) ||
                       (data_pin_swap_mask != data_pin_polarity_swap);

  ////////////////////////////////////////////////////////////////////////////
  // Read path, zero-wait answer

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[`UHPD_STS_FROZEN] = hub_attached;
    status[`UHPD_STS_PENDING] = pending;
  end

  wire logic [7:0] rd_byte = hit_upper ? downstream_upper_drive_boost :
                             hit_lower ? downstream_lower_drive_boost :
                             hit_swap ? data_pin_polarity_swap :
                             hit_status ? status : 8'h00;

  assign pready = 1'b1;
  assign pslverr = access && bad_access;
  assign prdata = (access && !pwrite && !bad_access) ? {24'h000000, rd_byte} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Boost decode

  logic [NUM_DS-1:0][1:0] boost_code;
  uhpd_drive_t drive_level [NUM_DS];

  assign boost_code[0] = boost_field(applied_lower, `UHPD_P1_LSB);   // RULE2
  assign boost_code[1] = boost_field(applied_lower, `UHPD_P2_LSB);
  assign boost_code[2] = boost_field(applied_lower, `UHPD_P3_LSB);
  assign boost_code[3] = boost_field(applied_lower, `UHPD_P4_LSB);
  assign boost_code[4] = boost_field(applied_upper, `UHPD_P5_LSB);   // RULE1
  assign boost_code[5] = boost_field(applied_upper, `UHPD_P6_LSB);
  assign boost_code[6] = boost_field(applied_upper, `UHPD_P7_LSB);

  uhpd_boost_decode #(
    .N(NUM_DS)
  ) uhpd_boost_decode_i (
    .code(boost_code),
    .level(drive_level),
    .boost_pct(boost_pct)
  );

  assign port1_drive_level = drive_level[0];
  assign port2_drive_level = drive_level[1];
  assign port3_drive_level = drive_level[2];
  assign port4_drive_level = drive_level[3];
  assign port5_drive_level = drive_level[4];
  assign port6_drive_level = drive_level[5];
  assign port7_drive_level = drive_level[6];

  ////////////////////////////////////////////////////////////////////////////
  // Data pin swap: index 0 upstream, index n downstream port n

  uhpd_pin_swap #(
    .N(NUM_DS + 1)
  ) uhpd_pin_swap_i (
    .swap(data_pin_swap_mask),   // RULE9 RULE10
    .core_tx(core_tx),
    .core_oe_n(core_oe_n),
    .core_rx(core_rx),
    .pin_out(data_pin_out),
    .pin_oe_n(data_pin_oe_n),
    .pin_in(data_pin_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Attach level one edge back, kept in a flop so the swap bit 7 check needs no sampled-value call
  logic attached_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attached_q <= 1'b0;
    end else begin
      attached_q <= hub_attached;
    end
  end

  wire logic detached_write = !hub_attached && !attached_q;

  a_upper_port7_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    wr_upper && !hub_attached ##1 !hub_attached |=>
      port7_drive_level == uhpd_drive_t'($past(pwdata[5:4], 2)))
    else $error("port 7 boost not taken from upper bits 5:4");

  a_upper_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    wr_upper |=> downstream_upper_drive_boost[7:6] == 2'h0 &&
      downstream_upper_drive_boost[5:0] == $past(pwdata[5:0]))
    else $error("upper boost reserved bits not zero or field lost");

  a_lower_port4_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    wr_lower && !hub_attached ##1 !hub_attached |=>
      port4_drive_level == uhpd_drive_t'($past(pwdata[7:6], 2)) &&
      port1_drive_level == uhpd_drive_t'($past(pwdata[1:0], 2)))
    else $error("ports 4 or 1 boost not taken from lower register");

  a_zero_normal_drive: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    applied_lower[3:2] == 2'h0 |-> port2_drive_level == drv_normal && boost_pct[1] == 4'h0)
    else $error("zero boost code does not give normal drive");

  a_code_level_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    applied_upper[3:2] == 2'h3 |-> port6_drive_level == drv_high && boost_pct[5] == 4'hc)
    else $error("boost code 11 does not give high drive");

  a_swap_clear_pass: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !data_pin_swap_mask[`UHPD_SWAP_UPSTREAM] |->
      data_pin_out[0] == core_tx[0] && core_rx[0] == data_pin_in[0])
    else $error("unswapped upstream port does not pass lines straight");

  a_swap_set_cross: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    data_pin_swap_mask[3] |-> data_pin_out[3].pos == core_tx[3].neg &&
      data_pin_out[3].neg == core_tx[3].pos && data_pin_oe_n[3].pos == core_oe_n[3].neg)
    else $error("swapped port 3 lines not exchanged");

  a_swap_bit7_port7: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    wr_swap && pwdata[7] && detached_write ##1 !hub_attached |=>
      data_pin_out[7].pos == core_tx[7].neg)
    else $error("swap bit 7 does not exchange port 7 pins");

  a_swap_bit_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    data_pin_swap_mask[1] != data_pin_swap_mask[2] |->
      data_pin_out[1].pos == (data_pin_swap_mask[1] ? core_tx[1].neg : core_tx[1].pos))
    else $error("swap bit 1 does not follow port 1");

  a_frozen_attached: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    hub_attached && $past(hub_attached) |->
      $stable(applied_upper) && $stable(applied_lower) && $stable(data_pin_swap_mask))
    else $error("applied settings changed while attached");

  a_pending_status: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (wr_upper && pwdata[5:0] != applied_upper[5:0] && hub_attached) ##1 hub_attached |->
      status[`UHPD_STS_PENDING])
    else $error("write while attached not shown as pending");

  a_apply_detached: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    !hub_attached |=> applied_upper == $past(downstream_upper_drive_boost) &&
      applied_lower == $past(downstream_lower_drive_boost) &&
      data_pin_swap_mask == $past(data_pin_polarity_swap))
    else $error("applied settings do not follow registers while detached");

  a_lower_port3_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    wr_lower && !hub_attached ##1 !hub_attached |=>
      port3_drive_level == uhpd_drive_t'($past(pwdata[5:4], 2)) &&
      port2_drive_level == uhpd_drive_t'($past(pwdata[3:2], 2)))
    else $error("ports 3 or 2 boost not taken from lower register");

  a_upper_port6_map: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    wr_upper && !hub_attached ##1 !hub_attached |=>
      port6_drive_level == uhpd_drive_t'($past(pwdata[3:2], 2)) &&
      port5_drive_level == uhpd_drive_t'($past(pwdata[1:0], 2)))
    else $error("ports 6 or 5 boost not taken from upper register");

  // Every port checked, not only the sampled ones above
  for (genvar i = 0; i < NUM_DS; i++) begin : g_boost_chk
    a_boost_code_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      boost_code[i] == 2'h0 |-> drive_level[i] == drv_normal && boost_pct[i] == 4'h0)
      else $error("boost code 00 does not give normal drive");
    a_boost_code_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      boost_code[i] == 2'h1 |-> drive_level[i] == drv_low && boost_pct[i] == 4'h4)
      else $error("boost code 01 does not give low drive");
    a_boost_code_mid: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      boost_code[i] == 2'h2 |-> drive_level[i] == drv_medium && boost_pct[i] == 4'h8)
      else $error("boost code 10 does not give medium drive");
  end

  for (genvar i = 0; i <= NUM_DS; i++) begin : g_swap_chk
    a_swap_port_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      data_pin_swap_mask[i] |-> data_pin_out[i].pos == core_tx[i].neg &&
        data_pin_out[i].neg == core_tx[i].pos && core_rx[i].neg == data_pin_in[i].pos)
      else $error("swap bit does not exchange the lines of its own port");
    a_swap_port_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      !data_pin_swap_mask[i] |-> data_pin_out[i] == core_tx[i] &&
        data_pin_oe_n[i] == core_oe_n[i] && core_rx[i] == data_pin_in[i])
      else $error("unswapped port does not pass lines straight");
  end

endmodule
`default_nettype wire

// [verification/uhpd_pad_model.sv]
// Pad-side model of the data lines between the hub and the far USB device
`timescale 1ns/100ps
`default_nettype none
module uhpd_pad_model (
  input wire uhpd_pkg::uhpd_line_t [7:0] data_pin_out,
  input wire uhpd_pkg::uhpd_line_t [7:0] data_pin_oe_n,
  input wire uhpd_pkg::uhpd_line_t [7:0] ext_level,
  output uhpd_pkg::uhpd_line_t [7:0] data_pin_in
);
  import uhpd_pkg::*;
  // Hub owns a line while its enable is low; otherwise the device drives it
  for (genvar i = 0; i < 8; i++) begin : g_line
    assign data_pin_in[i].pos = data_pin_oe_n[i].pos ? ext_level[i].pos : data_pin_out[i].pos;
    assign data_pin_in[i].neg = data_pin_oe_n[i].neg ? ext_level[i].neg : data_pin_out[i].neg;
  end
endmodule
`default_nettype wire

// [verification/test_usb_hub_port_drive_swap_cfg.sv]
// Self-checking bench of the hub port drive boost and data pin swap registers
`timescale 1ns/100ps
`default_nettype none
module test_usb_hub_port_drive_swap_cfg;
  import uhpd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, hub_attached, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] up, lo, sw;
  uhpd_drive_t lv [7];
  logic [6:0][3:0] boost_pct;
  uhpd_line_t [7:0] core_tx, core_oe_n, core_rx, pin_out, pin_oe_n, pin_in, ext;
  logic [11:0] bad_a [3] = '{12'h3f8, 12'h3dd, 12'h3f4};
  logic bad_w [3] = '{1'b0, 1'b0, 1'b1};
  int fails, compares, wt;

  uhpd_cfg_top #(.ADDR_W(12), .NUM_DS(7)) uhpd_cfg_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hub_attached(hub_attached), .port1_drive_level(lv[0]), .port2_drive_level(lv[1]),
    .port3_drive_level(lv[2]), .port4_drive_level(lv[3]), .port5_drive_level(lv[4]),
    .port6_drive_level(lv[5]), .port7_drive_level(lv[6]), .boost_pct(boost_pct),
    .core_tx(core_tx), .core_oe_n(core_oe_n), .core_rx(core_rx), .data_pin_out(pin_out),
    .data_pin_oe_n(pin_oe_n), .data_pin_in(pin_in));
  uhpd_pad_model uhpd_pad_model_i (.data_pin_out(pin_out), .data_pin_oe_n(pin_oe_n),
    .ext_level(ext), .data_pin_in(pin_in));

  function automatic uhpd_line_t swp(input uhpd_line_t x, input logic s);
    return s ? {x.neg, x.pos} : x;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wt = 0;
    while (pready !== 1'b1) begin
      wt++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rb(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", rd, e);
    chk("slverr", {31'h0, err}, 32'h0);
    // Register bank answers in the access cycle itself
    chk("wait states", wt, 32'h0);
  endtask

  task automatic cfg(input logic [7:0] u, input logic [7:0] l, input logic [7:0] s);
    apb(1'b1, 12'h3dc, {24'h0, u});
    apb(1'b1, 12'h3e0, {24'h0, l});
    apb(1'b1, 12'h3e8, {24'h0, s});
  endtask

  task automatic check_outs(input logic [7:0] u, input logic [7:0] l, input logic [7:0] s);
    logic [13:0] c;
    c = {u[5:0], l};
    @(posedge pclk);
    core_tx <= 16'($urandom);
    core_oe_n <= 16'($urandom);
    ext <= 16'($urandom);
    @(negedge pclk);
    for (int i = 0; i < 7; i++) begin
      chk("drive level", 32'(lv[i]), 32'(c[2*i+:2]));
      chk("boost pct", 32'(boost_pct[i]), 32'(c[2*i+:2]) * 4);
    end
    for (int i = 0; i < 8; i++) begin
      chk("pin out", 32'(pin_out[i]), 32'(swp(core_tx[i], s[i])));
      chk("pin oe_n", 32'(pin_oe_n[i]), 32'(swp(core_oe_n[i], s[i])));
      chk("core rx", 32'(core_rx[i]), 32'(swp(pin_in[i], s[i])));
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Far above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end

  initial begin
    fails = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, hub_attached} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    {core_tx, core_oe_n, ext} = 48'h0;
    void'($urandom(32'h87b1));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rb(12'h3dc, 32'h0);
    rb(12'h3e0, 32'h0);
    rb(12'h3e8, 32'h0);
    check_outs(8'h00, 8'h00, 8'h00);
    // First passes pin every code and the top swap bit, then random
    for (int k = 0; k < 16; k++) begin
      up = (k == 0) ? 8'hff : 8'($urandom);
      lo = (k == 0) ? 8'he4 : 8'($urandom);
      sw = (k == 1) ? 8'h80 : (k == 2) ? 8'h01 : 8'($urandom);
      cfg(up, lo, sw);
      rb(12'h3dc, {24'h0, up & 8'h3f});
      rb(12'h3e0, {24'h0, lo});
      rb(12'h3e8, {24'h0, sw});
      repeat (2) @(posedge pclk);
      check_outs(up, lo, sw);
    end
    // Lane 0 strobe low stores nothing
    @(posedge pclk);
    pstrb <= 4'h0;
    apb(1'b1, 12'h3e0, {24'h0, ~lo});
    pstrb <= 4'hf;
    rb(12'h3e0, {24'h0, lo});
    // Attached hub keeps the applied settings while writes sit pending
    @(posedge pclk);
    hub_attached <= 1'b1;
    cfg(~up, ~lo, ~sw);
    rb(12'h3f4, 32'h3);
    check_outs(up, lo, sw);
    @(posedge pclk);
    hub_attached <= 1'b0;
    repeat (2) @(posedge pclk);
    check_outs(~up, ~lo, ~sw);
    for (int i = 0; i < 3; i++) begin
      apb(bad_w[i], bad_a[i], 32'hff);
      chk("slverr", {31'h0, err}, 32'h1);
      chk("read data", rd, 32'h0);
    end
    rb(12'h3e8, {24'h0, ~sw});
    cfg(8'h00, 8'h00, 8'h00);
    repeat (2) @(posedge pclk);
    check_outs(8'h00, 8'h00, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
